// ### hw/bcb_pkg.sv
// Shared constants and types for the bit clear and conditional branch executor.
package bcb_pkg;

  localparam int unsigned INSTR_W  = 16;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FADDR_W  = 8;
  localparam int unsigned BANK_W   = 4;
  localparam int unsigned DADDR_W  = 12;
  localparam int unsigned PC_W     = 21;
  localparam int unsigned BIT_W    = 3;

  // Opcode fields: top nibble for bit clear, top byte for the branches.
  localparam logic [3:0] BIT_CLEAR_NIB   = 4'h9;
  localparam logic [7:0] BR_CARRY_BYTE   = 8'he2;
  localparam logic [7:0] BR_NO_CARRY_BYTE = 8'he3;
  localparam logic [7:0] BR_NEG_BYTE     = 8'he6;

  // Access bank layout: low part maps to bank zero, high part to the top bank.
  localparam logic [7:0]        ACCESS_SPLIT    = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK  = 4'hf;

  // Values after reset.
  localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
  localparam logic [INSTR_W-1:0] IR_RST    = 16'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;
  localparam logic [DADDR_W-1:0] DADDR_RST = 12'h000;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } bcb_phase_t;

  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_BIT_CLEAR   = 3'b001,
    OP_BR_NEG      = 3'b010,
    OP_BR_CARRY    = 3'b011,
    OP_BR_NO_CARRY = 3'b100
  } bcb_op_t;

endpackage : bcb_pkg

// ### hw/bcb_dec_if.sv
// Carrier between the executor core and its instruction decoder.
`timescale 1ns/100ps
`default_nettype none
interface bcb_dec_if;
  logic [bcb_pkg::INSTR_W-1:0] word;
  bcb_pkg::bcb_op_t            op;
  logic [bcb_pkg::BIT_W-1:0]   bit_idx;
  logic                        acc_sel;
  logic [bcb_pkg::FADDR_W-1:0] faddr;
  logic [7:0]                  offset;

  modport dec  (input word, output op, bit_idx, acc_sel, faddr, offset);
  modport core (output word, input op, bit_idx, acc_sel, faddr, offset);
endinterface : bcb_dec_if
`default_nettype wire

// ### hw/bcb_decode.sv
// Instruction field decoder for bit clear and the conditional branches.
`timescale 1ns/100ps
`default_nettype none
module bcb_decode (
  bcb_dec_if.dec d
);

  wire is_bit_clear;
  wire is_br_neg;
  wire is_br_carry;
  wire is_br_no_carry;

  assign is_bit_clear   = (d.word[15:12] == bcb_pkg::BIT_CLEAR_NIB);
  assign is_br_neg      = (d.word[15:8] == bcb_pkg::BR_NEG_BYTE);
  assign is_br_carry    = (d.word[15:8] == bcb_pkg::BR_CARRY_BYTE);
  assign is_br_no_carry = (d.word[15:8] == bcb_pkg::BR_NO_CARRY_BYTE);

  // Words outside this group decode to no operation here.
  assign d.op = is_bit_clear   ? bcb_pkg::OP_BIT_CLEAR   :
                is_br_neg      ? bcb_pkg::OP_BR_NEG      :
                is_br_carry    ? bcb_pkg::OP_BR_CARRY    :
                is_br_no_carry ? bcb_pkg::OP_BR_NO_CARRY : bcb_pkg::OP_NONE;

  assign d.bit_idx = d.word[11:9];
  assign d.acc_sel = d.word[8];
  assign d.faddr   = d.word[7:0];
  assign d.offset  = d.word[7:0];

endmodule : bcb_decode
`default_nettype wire

// ### hw/bcb_exec.sv
// Four-phase executor for bit clear and the carry and negative branches.
//
// Operation
// - Word 1001 bbba ffff ffff clears bit b of the addressed register only.
// - Access bit 0 selects the access bank; 1 uses the bank select register.
// - High byte 1110 0110 branches only when the negative flag is one.
// - High byte 1110 0011 with an eight-bit offset is the no-carry branch.
// - No-carry branch is taken only with carry clear, else execution falls through.
// - Branch offset is signed, -128 to 127, and doubled before the add.
// - Taken target is branch address plus two plus twice the offset.
// - Branches take one cycle when not taken and two cycles when taken.
// - Conditional branches never modify any arithmetic status flag.
// - High byte 1110 0010 branches only when the carry flag is one.
`timescale 1ns/100ps
`default_nettype none
module bcb_exec (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [bcb_pkg::INSTR_W-1:0]   instr_i,
  input  wire logic [bcb_pkg::PC_W-1:0]      pc_i,
  input  wire logic [bcb_pkg::BANK_W-1:0]    bank_select_register_i,
  input  wire logic                          carry_i,
  input  wire logic                          negative_i,
  input  wire logic [bcb_pkg::DATA_W-1:0]    dm_rdata_i,
  output logic      [1:0]                    phase_o,
  output logic      [bcb_pkg::DADDR_W-1:0]   dm_addr_o,
  output logic                               dm_rd_o,
  output logic                               dm_wr_o,
  output logic      [bcb_pkg::DATA_W-1:0]    dm_wdata_o,
  output logic                               pc_load_o,
  output logic      [bcb_pkg::PC_W-1:0]      pc_target_o,
  output logic                               flush_o,
  output logic                               nop_cycle_o,
  output logic                               flags_we_o
);

  bcb_pkg::bcb_phase_t phase_q;
  bcb_pkg::bcb_phase_t phase_d;

  logic [bcb_pkg::INSTR_W-1:0] ir_q;
  logic [bcb_pkg::PC_W-1:0]    pc_q;
  logic                        nop_q;
  logic                        nop_d;
  logic [bcb_pkg::DATA_W-1:0]  rdata_q;
  logic [bcb_pkg::DADDR_W-1:0] addr_q;
  logic [bcb_pkg::DADDR_W-1:0] addr_d;
  logic                        rd_q;
  logic                        rd_d;
  logic                        wr_q;
  logic                        wr_d;
  logic [bcb_pkg::DATA_W-1:0]  wdata_q;
  logic [bcb_pkg::DATA_W-1:0]  wdata_d;
  logic                        pc_load_q;
  logic                        pc_load_d;
  logic [bcb_pkg::PC_W-1:0]    target_q;
  logic [bcb_pkg::PC_W-1:0]    target_d;
  logic                        flush_q;
  logic                        flush_d;

  bcb_dec_if dec_bus ();

  bcb_decode u_decode (
    .d (dec_bus)
  );

  wire                          in_q1;
  wire                          in_q2;
  wire                          in_q3;
  wire                          in_q4;
  wire                          busy_nop;
  wire                          op_bit_clear;
  wire                          op_branch;
  wire                          cond_true;
  wire                          taken;
  wire [bcb_pkg::BANK_W-1:0]    access_bank;
  wire [bcb_pkg::BANK_W-1:0]    eff_bank;
  wire [bcb_pkg::DADDR_W-1:0]   eff_addr;
  wire [bcb_pkg::PC_W-1:0]      offset_x2;
  wire [bcb_pkg::PC_W-1:0]      branch_target;
  wire [bcb_pkg::DATA_W-1:0]    cleared;

  assign in_q1    = (phase_q == bcb_pkg::PH_Q1);
  assign in_q2    = (phase_q == bcb_pkg::PH_Q2);
  assign in_q3    = (phase_q == bcb_pkg::PH_Q3);
  assign in_q4    = (phase_q == bcb_pkg::PH_Q4);
  assign busy_nop = nop_q;

  // The fetched word is decoded live in phase one, then from the latched copy.
  assign dec_bus.word = in_q1 ? instr_i : ir_q;

  assign op_bit_clear = !busy_nop && (dec_bus.op == bcb_pkg::OP_BIT_CLEAR);
  assign op_branch    = !busy_nop && ((dec_bus.op == bcb_pkg::OP_BR_NEG)   ||
                                      (dec_bus.op == bcb_pkg::OP_BR_CARRY) ||
                                      (dec_bus.op == bcb_pkg::OP_BR_NO_CARRY));

  // negative condition, carry set, carry clear.
  // Flags are read live here, so the decision is fixed only at the end of phase three.
  assign cond_true = ((dec_bus.op == bcb_pkg::OP_BR_NEG)      &&  negative_i) ||
                     ((dec_bus.op == bcb_pkg::OP_BR_CARRY)    &&  carry_i)    ||
                     ((dec_bus.op == bcb_pkg::OP_BR_NO_CARRY) && !carry_i);
  assign taken     = op_branch && cond_true;

  assign access_bank = (dec_bus.faddr < bcb_pkg::ACCESS_SPLIT) ? bcb_pkg::ACCESS_LOW_BANK
                                                                : bcb_pkg::ACCESS_HI_BANK;
  assign eff_bank    = dec_bus.acc_sel ? bank_select_register_i : access_bank;
  assign eff_addr    = {eff_bank, dec_bus.faddr};

  assign offset_x2     = {{(bcb_pkg::PC_W-9){dec_bus.offset[7]}}, dec_bus.offset, 1'b0};
  assign branch_target = pc_q + offset_x2;

  // clear selected bit only.
  // The index is widened to int so the loop variable needs no narrowing.
  for (genvar i = 0; i < bcb_pkg::DATA_W; i++) begin : g_clear
    assign cleared[i] = rdata_q[i] & (int'(dec_bus.bit_idx) != i);
  end

  // Phase sequencer: one phase per clock, four clocks per instruction cycle.
  always_comb begin
    case (phase_q)
      bcb_pkg::PH_Q1: phase_d = bcb_pkg::PH_Q2;
      bcb_pkg::PH_Q2: phase_d = bcb_pkg::PH_Q3;
      bcb_pkg::PH_Q3: phase_d = bcb_pkg::PH_Q4;
      bcb_pkg::PH_Q4: phase_d = bcb_pkg::PH_Q1;
      default:        phase_d = bcb_pkg::PH_Q1;
    endcase
  end

  assign rd_d    = in_q1 && op_bit_clear;
  assign addr_d  = (in_q1 && op_bit_clear) ? eff_addr : addr_q;
  assign wr_d    = in_q3 && op_bit_clear;
  assign wdata_d = (in_q3 && op_bit_clear) ? cleared : wdata_q;

  // taken branch writes the counter in phase four.
  assign pc_load_d = in_q3 && taken;
  assign target_d  = (in_q3 && taken) ? branch_target : target_q;
  // discard the prefetched word on a taken branch.
  assign flush_d   = in_q3 && taken;

  // one extra no-operation cycle after a taken branch.
  // the whole following cycle is idle.
  // Follow the registered load, since a flag change in phase four must not split load and idle cycle.
  assign nop_d = in_q4 ? pc_load_q : nop_q;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= bcb_pkg::PH_Q1;
      nop_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      nop_q   <= nop_d;
    end
  end

  // Latch the instruction and the advanced counter at the end of phase one.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_q <= bcb_pkg::IR_RST;
      pc_q <= bcb_pkg::PC_RST;
    end else if (in_q1) begin
      ir_q <= busy_nop ? bcb_pkg::IR_RST : instr_i;
      pc_q <= pc_i;
    end
  end

  // capture read data at the end of phase two.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= bcb_pkg::DATA_RST;
    end else if (in_q2 && op_bit_clear) begin
      rdata_q <= dm_rdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q  <= bcb_pkg::DADDR_RST;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wdata_q <= bcb_pkg::DATA_RST;
    end else begin
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      wdata_q <= wdata_d;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_q <= 1'b0;
      target_q  <= bcb_pkg::PC_RST;
      flush_q   <= 1'b0;
    end else begin
      pc_load_q <= pc_load_d;
      target_q  <= target_d;
      flush_q   <= flush_d;
    end
  end

  // The read address is held through phase four so the write lands on the same register.
  assign dm_addr_o   = addr_q;
  assign dm_rd_o     = rd_q;
  assign dm_wr_o     = wr_q;
  assign dm_wdata_o  = wdata_q;
  assign pc_load_o   = pc_load_q;
  assign pc_target_o = target_q;
  assign flush_o     = flush_q;
  assign nop_cycle_o = nop_q;
  assign phase_o     = phase_q;
  assign flags_we_o  = 1'b0;

endmodule : bcb_exec
`default_nettype wire

// ### verification/bcb_exec_monitor.sv
// Assertion checker for the bit clear and branch executor.
`timescale 1ns/100ps
`default_nettype none
module bcb_exec_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] instr_i,
  input wire logic [20:0] pc_i,
  input wire logic [3:0]  bank_select_register_i,
  input wire logic        carry_i,
  input wire logic        negative_i,
  input wire logic [7:0]  dm_rdata_i,
  input wire logic [1:0]  phase_o,
  input wire logic [11:0] dm_addr_o,
  input wire logic        dm_rd_o,
  input wire logic        dm_wr_o,
  input wire logic [7:0]  dm_wdata_o,
  input wire logic        pc_load_o,
  input wire logic [20:0] pc_target_o,
  input wire logic        flush_o,
  input wire logic        nop_cycle_o,
  input wire logic        flags_we_o
);
  logic        acc;
  logic        is_bc;
  logic [15:0] ir_q;
  assign acc   = phase_o == 2'h0 && !nop_cycle_o;
  assign is_bc = instr_i[15:12] == bcb_pkg::BIT_CLEAR_NIB;
  // Keeps the accepted word, so later phases are judged against it.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      ir_q <= 16'h0000;
    else if (acc)
      ir_q <= instr_i;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence bc_steps;
    ##1 dm_rd_o ##1 !dm_wr_o ##1 dm_wr_o;
  endsequence
  sequence idle_cycle;
    nop_cycle_o [*4] ##1 !nop_cycle_o;
  endsequence
  a_bc_steps: assert property (acc && is_bc |-> bc_steps)
    else $error("bit clear strobes out of step");
  a_rd_phase: assert property (dm_rd_o |-> phase_o == 2'h1 && ir_q[15:12] == bcb_pkg::BIT_CLEAR_NIB)
    else $error("read strobe out of place");
  a_wdata_clear: assert property (dm_wr_o |-> dm_wdata_o == ($past(dm_rdata_i, 2) & ~(8'h01 << ir_q[11:9])))
    else $error("write data wrong");
  a_addr_select: assert property (acc && is_bc |=> dm_addr_o == (ir_q[8] ?
    {$past(bank_select_register_i), ir_q[7:0]} :
    {(ir_q[7] ? bcb_pkg::ACCESS_HI_BANK : bcb_pkg::ACCESS_LOW_BANK), ir_q[7:0]}))
    else $error("data address wrong");
  // Flags count at the end of phase three, one cycle before the load.
  a_branch_cond: assert property (phase_o == 2'h3 && !nop_cycle_o |-> pc_load_o == (
    ir_q[15:8] == bcb_pkg::BR_CARRY_BYTE && $past(carry_i) ||
    ir_q[15:8] == bcb_pkg::BR_NO_CARRY_BYTE && !$past(carry_i) ||
    ir_q[15:8] == bcb_pkg::BR_NEG_BYTE && $past(negative_i)))
    else $error("branch decision wrong");
  a_target_calc: assert property (pc_load_o |-> pc_target_o == $past(pc_i, 3) + {{12{ir_q[7]}}, ir_q[7:0], 1'b0})
    else $error("branch target wrong");
  a_flush_pair: assert property (pc_load_o == flush_o)
    else $error("flush apart from load");
  a_nop_after: assert property (pc_load_o |=> idle_cycle)
    else $error("idle cycle length wrong");
  a_nop_quiet: assert property (nop_cycle_o |-> !dm_rd_o && !dm_wr_o && !pc_load_o)
    else $error("activity in idle cycle");
  a_flags_kept: assert property (!flags_we_o)
    else $error("flag write seen");
endmodule : bcb_exec_monitor
bind bcb_exec bcb_exec_monitor mon (.sys_clk_i, .rst_i, .instr_i, .pc_i, .bank_select_register_i, .carry_i,
  .negative_i, .dm_rdata_i, .phase_o, .dm_addr_o, .dm_rd_o, .dm_wr_o, .dm_wdata_o, .pc_load_o, .pc_target_o,
  .flush_o, .nop_cycle_o, .flags_we_o);
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the bit clear and branch executor.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [15:0] ins; logic [20:0] pc; logic [3:0] bank_select_register; logic [1:0] nc;
    logic [7:0] rd; logic ld; logic [20:0] ex;} bcb_row_t;
  logic        clk = 1'b0, rst = 1'b1, cy = 1'b0, ng = 1'b0, rds, wrs, ld, fl, nop, fwe;
  logic [15:0] ins = 16'h0000;
  logic [20:0] pc = 21'h0, tg;
  logic [3:0]  bank_select_register = 4'h0;
  logic [7:0]  rd = 8'h00, wd;
  logic [11:0] ad;
  logic [1:0]  ph;
  int          fail_count = 0;
  int          tests_run = 0;
  // Bit clear rows hold {address, data} in ex; taken branches hold the target.
  bcb_row_t    rows [10] = '{
    '{16'h9e12, 21'h0, 4'h5, 2'h0, 8'hc7, 1'h0, 21'h01247},
    '{16'h9134, 21'h0, 4'h5, 2'h0, 8'hff, 1'h0, 21'h534fe},
    '{16'h9680, 21'h0, 4'h5, 2'h0, 8'h08, 1'h0, 21'hf8000},
    '{16'he205, 21'h102, 4'h0, 2'h1, 8'h00, 1'h1, 21'h10c},
    '{16'he205, 21'h102, 4'h0, 2'h2, 8'h00, 1'h0, 21'h0},
    '{16'he380, 21'h1000, 4'h0, 2'h0, 8'h00, 1'h1, 21'hf00},
    '{16'he380, 21'h1000, 4'h0, 2'h1, 8'h00, 1'h0, 21'h0},
    '{16'he67f, 21'h200, 4'h0, 2'h2, 8'h00, 1'h1, 21'h2fe},
    '{16'he67f, 21'h200, 4'h0, 2'h1, 8'h00, 1'h0, 21'h0},
    '{16'h8e12, 21'h0, 4'h0, 2'h3, 8'h00, 1'h0, 21'h0}};
  bcb_exec uut (.sys_clk_i(clk), .rst_i(rst), .instr_i(ins), .pc_i(pc), .bank_select_register_i(bank_select_register),
    .carry_i(cy), .negative_i(ng), .dm_rdata_i(rd), .phase_o(ph), .dm_addr_o(ad), .dm_rd_o(rds),
    .dm_wr_o(wrs), .dm_wdata_o(wd), .pc_load_o(ld), .pc_target_o(tg), .flush_o(fl), .nop_cycle_o(nop),
    .flags_we_o(fwe));
  always #2 clk = ~clk;
  task automatic ckv(input string nm, input logic [20:0] e, input logic [20:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : ckv
  // The late carry lc replaces the carry after decode, as flags count at phase three.
  task automatic run(input bcb_row_t r, input logic lc);
    for (int k = 0; k < 8 && (ph !== 2'h0 || nop !== 1'b0); k++) @(posedge clk) #1;
    {ins, pc, bank_select_register, ng, cy, rd} = {r.ins, r.pc, r.bank_select_register, r.nc, r.rd};
    @(posedge clk) #1;
    cy = lc;
    ckv("rd_strobe", r.ins[15:12] == 4'h9, rds);
    if (r.ins[15:12] == 4'h9) ckv("addr", r.ex[19:8], ad);
    repeat (2) @(posedge clk) #1;
    ckv("phase", 21'h3, ph);
    ckv("wr_strobe", r.ins[15:12] == 4'h9, wrs);
    if (r.ins[15:12] == 4'h9) ckv("wdata", r.ex[7:0], wd);
    ckv("pc_load", r.ld, ld);
    ckv("flush", r.ld, fl);
    if (r.ld) ckv("target", r.ex, tg);
    ckv("flags_we", 1'b0, fwe);
    @(posedge clk) #1;
    ckv("nop_cycle", r.ld, nop);
    $display("test %h done", r.ins);
  endtask : run
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // Thirteen instructions of four to eight clocks each; the limit leaves wide margin.
  initial begin
    #5000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 ckv("reset_outs", 21'h0, {2'h0, ph, rds, wrs, ld, fl, nop, ad});
    $display("test power-on reset done");
    rst = 1'b0;
    foreach (rows[i]) run(rows[i], rows[i].nc[0]);
    run('{16'he201, 21'h40, 4'h0, 2'h0, 8'h00, 1'h1, 21'h42}, 1'b1);
    ins = 16'h9e12;
    repeat (4) begin
      @(posedge clk) #1;
      ckv("idle_rd", 1'b0, rds);
      ckv("idle_wr", 1'b0, wrs);
    end
    $display("test idle cycle done");
    @(posedge clk) #1 rst = 1'b1;
    #1 ckv("mid_reset", 21'h0, {2'h0, ph, rds, wrs, ld, fl, nop, ad});
    $display("test mid-run reset done");
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    run('{16'he3fe, 21'h40, 4'h0, 2'h1, 8'h00, 1'h1, 21'h3c}, 1'b0);
    run(rows[0], 1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
